// file: src/mac_engine.sv
// Multiply-accumulate engine: 16x16 signed multiplier, 40-bit
// accumulator, shifter, rounding register and status flags.
// Assumes the processor core drives a same-clock register port:
// one write per cycle, reads are free of side effects.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Shift-control bit shifts the 40-bit accumulator next cycle, then self-clears.
// - Shift-direction bit: 0 shifts left, 1 shifts right.
// - Clear bit zeroes accumulator and resets status next cycle, then self-clears.
// - Saturate bit clamps the rounding register on overflow; accumulator untouched.
// - Config bit 1 picks integer (0) or fractional (1) numbers.
// - Config bit 0 picks accumulate (0) or multiply-only (1).
// - Upper two config bits read zero and ignore writes.
// - Upper four status bits read zero and ignore writes.
// - Hard overflow sets when the top byte crosses between 0x7F and 0x80.
// - Hard overflow stays set until software clears it or clear runs.
// - Zero flag follows whether the accumulator is zero after each operation.
// - Soft overflow follows overflow into bit 31, cleared when corrected.
// - Negative flag follows the accumulator sign after each operation.
// - Operand A is a high byte and a low byte register.
// - Writing operand B low byte starts an operation.
// - Three one-cycle stages: multiply, accumulate with flags, round.
// - Multiply-only mode leaves hard overflow unchanged.
// - Right shift sign-extends; shifts keep flags; rounding follows a cycle later.
// - Unbiased rounding of bits 31-16; saturation clamps to 0x7FFF or 0x8000.
module mac_engine (
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  input  wire mac_pkg::mac_sfr_req_t sfr_req,
  output logic [7:0]                 sfr_rdata
);

  // ==========================================================
  // State and decode
  mac_pkg::mac_cfg_t    cfg_r;
  mac_pkg::mac_status_t sta_r;
  logic [15:0]          a_r;
  logic [15:0]          b_r;
  logic [15:0]          b_op;
  logic [31:0]          prod_r;
  logic                 s1_r;
  logic                 rnd_go_r;
  logic [39:0]          acc_r;
  logic [15:0]          rnd_r;
  logic                 wr_cfg;
  logic                 wr_sta;
  logic                 wr_bl;
  logic                 wr_acc0;
  logic                 clr;
  logic                 shift_do;
  logic [39:0]          prod_ext;
  logic [39:0]          addend;
  logic [39:0]          sum;
  logic                 so_nxt;
  logic                 ho_evt;
  logic [15:0]          upper;
  logic [15:0]          lower;
  logic                 up;
  logic                 acc_ovf;
  logic [15:0]          rnd_nxt;

  assign wr_cfg  = sfr_req.wr && (sfr_req.addr == mac_pkg::MAC_ADDR_CONFIG);
  assign wr_sta  = sfr_req.wr && (sfr_req.addr == mac_pkg::MAC_ADDR_STATUS);
  assign wr_bl   = sfr_req.wr && (sfr_req.addr == mac_pkg::MAC_ADDR_B_LOW);
  assign wr_acc0 = sfr_req.wr && (sfr_req.addr == mac_pkg::MAC_ADDR_ACC0);

  // The low byte of B is taken straight from the bus on the starting edge,
  // because the register itself only holds it from the following cycle.
  assign b_op = wr_bl ? {b_r[15:8], sfr_req.wdata} : b_r;

  // A pending accumulate has priority over a shift; the shift bit then
  // simply stays set and the shift runs on the following cycle.
  assign clr      = cfg_r.clear_accumulator;
  assign shift_do = cfg_r.shift_control && !clr && !s1_r;

  // ==========================================================
  // Datapath
  // Extending before doubling keeps -1.0 * -1.0 representable.
  assign prod_ext = {{8{prod_r[31]}}, prod_r};
  assign addend   = cfg_r.fractional_select ? {prod_ext[38:0], 1'b0} : prod_ext;
  assign sum      = (cfg_r.multiply_only_select ? '0 : acc_r) + addend;
  assign so_nxt   = !((&sum[39:31]) || !(|sum[39:31]));
  assign ho_evt   = !cfg_r.multiply_only_select &&
                    (((acc_r[39:32] == mac_pkg::MAC_TOP_POS) &&
                      (sum[39:32] == mac_pkg::MAC_TOP_NEG)) ||
                     ((acc_r[39:32] == mac_pkg::MAC_TOP_NEG) &&
                      (sum[39:32] == mac_pkg::MAC_TOP_POS)));

  assign upper   = acc_r[31:16];
  assign lower   = acc_r[15:0];
  assign up      = (lower > mac_pkg::MAC_RND_HALF) ||
                   ((lower == mac_pkg::MAC_RND_HALF) && upper[0]);
  assign acc_ovf = !((&acc_r[39:31]) || !(|acc_r[39:31])) ||
                   (up && (upper == mac_pkg::MAC_SAT_POS));
  // Without saturation an overflowing result simply wraps.
  assign rnd_nxt = (cfg_r.saturate_select && acc_ovf) ?
                   (acc_r[39] ? mac_pkg::MAC_SAT_NEG : mac_pkg::MAC_SAT_POS) :
                   upper + {15'h0000, up};

  // ==========================================================
  // Configuration register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_r <= mac_pkg::MAC_CFG_RST;
    end else if (wr_cfg) begin
      // A fresh write wins over the hardware self-clear of the same cycle.
      cfg_r        <= sfr_req.wdata;
      cfg_r.unused <= '0;
    end else begin
      if (clr) begin
        cfg_r.clear_accumulator <= 1'b0;
      end
      if (shift_do) begin
        cfg_r.shift_control <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Status register
  always_ff @(posedge clk_sys) begin
    if (srst || clr) begin
      sta_r <= mac_pkg::MAC_STA_RST;
    end else if (s1_r) begin
      // Hardware updates win over a software write in the same cycle.
      sta_r.zero_flag          <= (sum == '0);
      sta_r.negative_flag      <= sum[39];
      sta_r.soft_overflow_flag <= so_nxt;
      sta_r.hard_overflow_flag <= sta_r.hard_overflow_flag | ho_evt;
    end else if (wr_sta) begin
      sta_r.hard_overflow_flag <= sfr_req.wdata[3];
      sta_r.zero_flag          <= sfr_req.wdata[2];
      sta_r.soft_overflow_flag <= sfr_req.wdata[1];
      sta_r.negative_flag      <= sfr_req.wdata[0];
    end
    // The unused bits are forced low every cycle rather than only on writes.
    sta_r.unused <= '0;
  end

  // ==========================================================
  // Operand registers and first stage
  // Operand A may be rewritten while an operation is in flight; only the
  // value present at the starting edge matters.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      a_r <= '0;
      b_r <= '0;
    end else if (sfr_req.wr) begin
      unique case (sfr_req.addr)
        mac_pkg::MAC_ADDR_A_LOW:  a_r[7:0]  <= sfr_req.wdata;
        mac_pkg::MAC_ADDR_A_HIGH: a_r[15:8] <= sfr_req.wdata;
        mac_pkg::MAC_ADDR_B_LOW:  b_r[7:0]  <= sfr_req.wdata;
        mac_pkg::MAC_ADDR_B_HIGH: b_r[15:8] <= sfr_req.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s1_r   <= 1'b0;
      prod_r <= '0;
    end else begin
      s1_r   <= wr_bl;
      prod_r <= $signed(a_r) * $signed(b_op);
    end
  end

  // ==========================================================
  // Accumulator: clear, then accumulate, then shift, then software
  always_ff @(posedge clk_sys) begin
    if (srst || clr) begin
      acc_r <= '0;
    end else if (s1_r) begin
      acc_r <= sum;
    end else if (shift_do) begin
      acc_r <= cfg_r.shift_direction ? {acc_r[39], acc_r[39:1]} :
                                       {acc_r[38:0], 1'b0};
    end else if (sfr_req.wr) begin
      // Software byte writes lose to any hardware update in the same cycle.
      for (int i = 0; i < mac_pkg::MAC_BYTES; i++) begin
        if (sfr_req.addr == mac_pkg::MAC_ADDR_ACC0 + 8'(i)) begin
          acc_r[i*8 +: 8] <= sfr_req.wdata;
        end
      end
    end
  end

  // ==========================================================
  // Third stage: rounding register
  // Rounding runs one cycle after an accumulate, a shift or a write to ACC0; a clear
  // or a write to the other accumulator bytes leaves the rounding register as it was.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rnd_go_r <= 1'b0;
      rnd_r    <= '0;
    end else begin
      rnd_go_r <= !clr && (s1_r || shift_do || wr_acc0);
      if (rnd_go_r) begin
        rnd_r <= rnd_nxt;
      end
    end
  end

  // ==========================================================
  // Read port, one cycle behind the address
  // Reads have no side effects, so the address may sit on the bus for as
  // long as the core likes.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sfr_rdata <= '0;
    end else begin
      unique case (sfr_req.addr)
        mac_pkg::MAC_ADDR_STATUS: sfr_rdata <= sta_r;
        mac_pkg::MAC_ADDR_A_LOW:  sfr_rdata <= a_r[7:0];
        mac_pkg::MAC_ADDR_A_HIGH: sfr_rdata <= a_r[15:8];
        mac_pkg::MAC_ADDR_CONFIG: sfr_rdata <= cfg_r;
        mac_pkg::MAC_ADDR_B_LOW:  sfr_rdata <= b_r[7:0];
        mac_pkg::MAC_ADDR_B_HIGH: sfr_rdata <= b_r[15:8];
        mac_pkg::MAC_ADDR_ACC0:   sfr_rdata <= acc_r[7:0];
        mac_pkg::MAC_ADDR_ACC1:   sfr_rdata <= acc_r[15:8];
        mac_pkg::MAC_ADDR_ACC2:   sfr_rdata <= acc_r[23:16];
        mac_pkg::MAC_ADDR_ACC3:   sfr_rdata <= acc_r[31:24];
        mac_pkg::MAC_ADDR_TOP:    sfr_rdata <= acc_r[39:32];
        mac_pkg::MAC_ADDR_RND_LO: sfr_rdata <= rnd_r[7:0];
        mac_pkg::MAC_ADDR_RND_HI: sfr_rdata <= rnd_r[15:8];
        default:                  sfr_rdata <= mac_pkg::MAC_ZERO8;
      endcase
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // These checks assume the core keeps to the ordering rules; a config write
  // inside the first two stages may trip them without a design fault.

  property p_cfg_unused;
    sfr_req.wr ##1 1'b1 |-> cfg_r.unused == 2'b00;
  endproperty
  a_cfg_unused: assert property (p_cfg_unused) else $error("config upper bits set");

  property p_sta_unused;
    wr_sta |=> sta_r.unused == 4'h0;
  endproperty
  a_sta_unused: assert property (p_sta_unused) else $error("status upper bits set");

  property p_shift_clears;
    shift_do && !wr_cfg |=> !cfg_r.shift_control;
  endproperty
  a_shift_clears: assert property (p_shift_clears) else $error("shift bit stuck");

  property p_shift_right;
    shift_do && cfg_r.shift_direction |=>
      acc_r == {$past(acc_r[39]), $past(acc_r[39:1])} && $stable(sta_r);
  endproperty
  a_shift_right: assert property (p_shift_right) else $error("bad right shift");

  property p_shift_left;
    shift_do && !cfg_r.shift_direction |=> acc_r == {$past(acc_r[38:0]), 1'b0};
  endproperty
  a_shift_left: assert property (p_shift_left) else $error("bad left shift");

  property p_clear;
    clr |=> acc_r == '0 && sta_r == mac_pkg::MAC_STA_RST && !rnd_go_r ##0
      (!$past(wr_cfg) -> !cfg_r.clear_accumulator);
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");

  property p_pipe;
    wr_bl && !clr |=> s1_r ##0 !clr[*1] ##1 rnd_go_r;
  endproperty
  a_pipe: assert property (p_pipe) else $error("pipeline timing wrong");

  property p_ho_sticky;
    sta_r.hard_overflow_flag && !clr && !wr_sta |=> sta_r.hard_overflow_flag;
  endproperty
  a_ho_sticky: assert property (p_ho_sticky) else $error("hard overflow lost");

  property p_ho_mult_only;
    s1_r && !clr && cfg_r.multiply_only_select |=> $stable(sta_r.hard_overflow_flag);
  endproperty
  a_ho_mult_only: assert property (p_ho_mult_only) else $error("hard overflow moved");

  property p_flags;
    s1_r && !clr |=> sta_r.zero_flag == (acc_r == '0) &&
      sta_r.negative_flag == acc_r[39] &&
      sta_r.soft_overflow_flag == !((&acc_r[39:31]) || !(|acc_r[39:31]));
  endproperty
  a_flags: assert property (p_flags) else $error("flags disagree with accumulator");

  property p_mult_only;
    s1_r && !clr && cfg_r.multiply_only_select |=> acc_r == $past(addend);
  endproperty
  a_mult_only: assert property (p_mult_only) else $error("multiply-only kept old value");

  property p_sat;
    rnd_go_r && cfg_r.saturate_select && !acc_r[39] && !acc_r[31] && (|acc_r[39:32])
      |=> rnd_r == mac_pkg::MAC_SAT_POS;
  endproperty
  a_sat: assert property (p_sat) else $error("no positive saturation");

  property p_sat_neg;
    rnd_go_r && cfg_r.saturate_select && acc_r[39] && !(&acc_r[39:31])
      |=> rnd_r == mac_pkg::MAC_SAT_NEG;
  endproperty
  a_sat_neg: assert property (p_sat_neg) else $error("no negative saturation");

  property p_start;
    wr_bl && !clr |=> s1_r;
  endproperty
  a_start: assert property (p_start) else $error("operand B low write did not start");

  property p_shift_rounds;
    shift_do |=> rnd_go_r;
  endproperty
  a_shift_rounds: assert property (p_shift_rounds) else $error("no rounding after shift");

  property p_round_down;
    rnd_go_r && !cfg_r.saturate_select && (acc_r[15:0] < mac_pkg::MAC_RND_HALF)
      |=> rnd_r == $past(acc_r[31:16]);
  endproperty
  a_round_down: assert property (p_round_down) else $error("rounding went up");

  property p_round_up;
    rnd_go_r && !cfg_r.saturate_select && (acc_r[15:0] > mac_pkg::MAC_RND_HALF)
      |=> rnd_r == $past(acc_r[31:16]) + 16'h0001;
  endproperty
  a_round_up: assert property (p_round_up) else $error("rounding went down");

  property p_ho_set;
    s1_r && !clr && !cfg_r.multiply_only_select && (acc_r[39:32] == mac_pkg::MAC_TOP_POS)
      |=> (acc_r[39:32] != mac_pkg::MAC_TOP_NEG) || sta_r.hard_overflow_flag;
  endproperty
  a_ho_set: assert property (p_ho_set) else $error("hard overflow not set");

  c_frac_mac:  cover property (s1_r && cfg_r.fractional_select && !cfg_r.multiply_only_select);
  c_shift_r:   cover property (shift_do && cfg_r.shift_direction ##1 shift_do);
  c_hard_ovf:  cover property (s1_r && ho_evt);
  c_saturated: cover property (rnd_go_r && cfg_r.saturate_select && acc_ovf);

endmodule

`default_nettype wire

// file: src/mac_pkg.sv
// Package for the multiply-accumulate engine: register addresses,
// field layouts, reset values and arithmetic constants.
// Assumes one synchronous clock domain shared with the processor core.
package mac_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [7:0] MAC_ADDR_STATUS = 8'hC0;
  localparam logic [7:0] MAC_ADDR_A_LOW  = 8'hC1;
  localparam logic [7:0] MAC_ADDR_A_HIGH = 8'hC2;
  localparam logic [7:0] MAC_ADDR_CONFIG = 8'hC3;
  localparam logic [7:0] MAC_ADDR_B_LOW  = 8'hC4;
  localparam logic [7:0] MAC_ADDR_B_HIGH = 8'hC5;
  localparam logic [7:0] MAC_ADDR_ACC0   = 8'h93;
  localparam logic [7:0] MAC_ADDR_ACC1   = 8'h94;
  localparam logic [7:0] MAC_ADDR_ACC2   = 8'h95;
  localparam logic [7:0] MAC_ADDR_ACC3   = 8'h96;
  localparam logic [7:0] MAC_ADDR_TOP    = 8'h97;
  localparam logic [7:0] MAC_ADDR_RND_LO = 8'hCE;
  localparam logic [7:0] MAC_ADDR_RND_HI = 8'hCF;

  // ==========================================================
  // Widths and reset values
  localparam int unsigned MAC_ACC_W   = 40;
  localparam int unsigned MAC_BYTES   = 5;
  localparam logic [7:0]  MAC_CFG_RST = 8'h00;
  localparam logic [7:0]  MAC_STA_RST = 8'h04;
  localparam logic [7:0]  MAC_ZERO8   = 8'h00;

  // ==========================================================
  // Arithmetic constants
  localparam logic [7:0]  MAC_TOP_POS  = 8'h7F;
  localparam logic [7:0]  MAC_TOP_NEG  = 8'h80;
  localparam logic [15:0] MAC_RND_HALF = 16'h8000;
  localparam logic [15:0] MAC_SAT_POS  = 16'h7FFF;
  localparam logic [15:0] MAC_SAT_NEG  = 16'h8000;

  // ==========================================================
  // Field layouts
  typedef struct packed {
    logic [1:0] unused;
    logic       shift_control;
    logic       shift_direction;
    logic       clear_accumulator;
    logic       saturate_select;
    logic       fractional_select;
    logic       multiply_only_select;
  } mac_cfg_t;

  typedef struct packed {
    logic [3:0] unused;
    logic       hard_overflow_flag;
    logic       zero_flag;
    logic       soft_overflow_flag;
    logic       negative_flag;
  } mac_status_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mac_sfr_req_t;

endpackage

// file: testbench/mac_core_model.sv
// Processor core model: drives the engine's register port through tasks.
// Assumes the caller enters each task just after a rising edge of clk_sys.
`timescale 1ns/10ps
`default_nettype none
module mac_core_model (
  input  wire logic                  clk_sys,
  output var  mac_pkg::mac_sfr_req_t sfr_req,
  input  wire logic [7:0]            sfr_rdata
);
  // ==========================================================
  // Port tasks
  initial sfr_req = '0;

  // A write stands for exactly the one edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    #1 sfr_req = '{wr: 1'b1, addr: a, wdata: d};
    @(posedge clk_sys);
  endtask

  // Idle data lines show the inverse of the last value, never a stale copy.
  task automatic idle(input int n);
    #1 sfr_req = '{wr: 1'b0, addr: 8'($urandom), wdata: ~sfr_req.wdata};
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    #1 sfr_req = '{wr: 1'b0, addr: a, wdata: ~sfr_req.wdata};
    @(posedge clk_sys);
    @(negedge clk_sys);
    d = sfr_rdata;
    @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the multiply-accumulate engine.
// Assumes the engine answers reads on the same edge that takes the address.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ==========================================================
  // Signals and model state
  logic                  clk_sys;
  logic                  srst;
  mac_pkg::mac_sfr_req_t sfr_req;
  logic [7:0]            sfr_rdata;
  logic [7:0]            rv;
  int                    num_errors;
  int                    cmp_count;
  logic [39:0]           acc;
  logic [3:0]            sta;
  logic [15:0]           rnd;
  logic                  sat;
  logic                  frac;
  logic                  monly;
  logic [15:0]           opa;
  logic [15:0]           opb;

  mac_engine dut (.clk_sys(clk_sys), .srst(srst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata));
  mac_core_model core (.clk_sys(clk_sys), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // Reference model
  function automatic logic [15:0] round_of(input logic [39:0] v, input logic s);
    logic [15:0] r;
    r = v[31:16] + 16'((v[15:0] > 16'h8000) || (v[15:0] == 16'h8000 && v[16]));
    if (s && (v[39:31] != {9{v[39]}} || (v[31:16] == 16'h7FFF && r == 16'h8000))) begin
      return v[39] ? mac_pkg::MAC_SAT_NEG : mac_pkg::MAC_SAT_POS;
    end
    return r;
  endfunction

  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic set_cfg(input logic s, input logic f, input logic m);
    sat = s;
    frac = f;
    monly = m;
    core.wr(mac_pkg::MAC_ADDR_CONFIG, {5'h00, s, f, m});
    core.idle(2);
  endtask

  // Each start is followed by three idle edges, so the pipeline is drained between starts.
  task automatic mac_op(input logic [15:0] a, input logic [15:0] b);
    longint     p;
    logic [7:0] top;
    core.wr(mac_pkg::MAC_ADDR_A_HIGH, a[15:8]);
    core.wr(mac_pkg::MAC_ADDR_A_LOW, a[7:0]);
    core.wr(mac_pkg::MAC_ADDR_B_HIGH, b[15:8]);
    core.wr(mac_pkg::MAC_ADDR_B_LOW, b[7:0]);
    p = longint'($signed(a)) * longint'($signed(b));
    if (frac) p = p <<< 1;
    top = acc[39:32];
    acc = monly ? p[39:0] : acc + p[39:0];
    if (!monly && ((top == 8'h7F && acc[39:32] == 8'h80) ||
                   (top == 8'h80 && acc[39:32] == 8'h7F))) sta[3] = 1'b1;
    sta[2:0] = {acc == 40'h0, acc[39:31] != {9{acc[39]}}, acc[39]};
    rnd = round_of(acc, sat);
    opa = a;
    opb = b;
    core.idle(3);
  endtask

  task automatic shift(input logic right);
    core.wr(mac_pkg::MAC_ADDR_CONFIG, {3'h1, right, 1'b0, sat, frac, monly});
    acc = right ? {acc[39], acc[39:1]} : {acc[38:0], 1'b0};
    rnd = round_of(acc, sat);
  endtask

  task automatic load_acc(input logic [39:0] v);
    for (int i = 4; i >= 0; i--) core.wr(8'(mac_pkg::MAC_ADDR_ACC0 + i), v[8*i +: 8]);
    acc = v;
    rnd = round_of(v, sat);
    core.idle(3);
  endtask

  task automatic compare_all();
    for (int i = 0; i < 5; i++) begin
      core.rd(8'(mac_pkg::MAC_ADDR_ACC0 + i), rv);
      check("acc", rv, acc[8*i +: 8]);
    end
    core.rd(mac_pkg::MAC_ADDR_STATUS, rv);
    check("status", rv, {4'h0, sta});
    core.rd(mac_pkg::MAC_ADDR_RND_LO, rv);
    check("rnd_lo", rv, rnd[7:0]);
    core.rd(mac_pkg::MAC_ADDR_RND_HI, rv);
    check("rnd_hi", rv, rnd[15:8]);
    core.rd(mac_pkg::MAC_ADDR_A_LOW, rv);
    check("a_low", rv, opa[7:0]);
    core.rd(mac_pkg::MAC_ADDR_A_HIGH, rv);
    check("a_high", rv, opa[15:8]);
    core.rd(mac_pkg::MAC_ADDR_B_LOW, rv);
    check("b_low", rv, opb[7:0]);
    core.rd(mac_pkg::MAC_ADDR_B_HIGH, rv);
    check("b_high", rv, opb[15:8]);
  endtask

  task automatic finish_test();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    repeat (60000) @(posedge clk_sys);
    num_errors++;
    finish_test();
  end

  initial begin
    srst = 1'b1;
    {num_errors, cmp_count} = '0;
    {acc, rnd, sat, frac, monly, opa, opb} = '0;
    sta = mac_pkg::MAC_STA_RST;
    void'($urandom(32'h671c));
    repeat (8) @(posedge clk_sys);
    #1 srst = 1'b0;
    compare_all();
    core.wr(mac_pkg::MAC_ADDR_CONFIG, 8'hC0);
    core.wr(mac_pkg::MAC_ADDR_STATUS, 8'hF4);
    core.rd(mac_pkg::MAC_ADDR_CONFIG, rv);
    check("config", rv, mac_pkg::MAC_CFG_RST);
    core.rd(mac_pkg::MAC_ADDR_STATUS, rv);
    check("status", rv, mac_pkg::MAC_STA_RST);
    // Fractional pair that cancels to zero, then an integer multiply-only.
    set_cfg(1'b0, 1'b1, 1'b0);
    mac_op(16'h4000, 16'h2000);
    mac_op(16'h4000, 16'hE000);
    compare_all();
    set_cfg(1'b0, 1'b0, 1'b1);
    mac_op(16'h1234, 16'hFEDC);
    compare_all();
    // One left shift, then two right shifts written back to back.
    load_acc(40'h4088442211);
    shift(1'b0);
    core.idle(3);
    compare_all();
    shift(1'b1);
    shift(1'b1);
    core.idle(3);
    compare_all();
    core.rd(mac_pkg::MAC_ADDR_CONFIG, rv);
    check("config", rv, 8'h11);
    // Crossing the top byte upward with saturation on, then stickiness.
    set_cfg(1'b1, 1'b0, 1'b0);
    load_acc(40'h7FFFFFFFFF);
    mac_op(16'h0001, 16'h0001);
    compare_all();
    mac_op(16'h0000, 16'h0000);
    set_cfg(1'b0, 1'b0, 1'b1);
    mac_op(16'h0001, 16'h0002);
    compare_all();
    core.wr(mac_pkg::MAC_ADDR_STATUS, 8'h00);
    sta = 4'h0;
    core.idle(2);
    set_cfg(1'b0, 1'b0, 1'b0);
    load_acc(40'h8000000000);
    mac_op(16'hFFFF, 16'h0001);
    compare_all();
    core.wr(mac_pkg::MAC_ADDR_CONFIG, 8'h08);
    acc = '0;
    sta = mac_pkg::MAC_STA_RST;
    core.idle(3);
    compare_all();
    core.rd(mac_pkg::MAC_ADDR_CONFIG, rv);
    check("config", rv, 8'h00);
    // Random operands and modes, with an occasional shift.
    repeat (24) begin
      set_cfg(1'($urandom), 1'($urandom), 1'($urandom));
      mac_op(16'($urandom), 16'($urandom));
      if ($urandom % 3 == 0) begin
        shift(1'($urandom));
        core.idle(3);
      end
      compare_all();
      // Rounding registers are read-only: a write must leave them alone.
      core.wr(mac_pkg::MAC_ADDR_RND_HI, 8'($urandom));
      core.idle(1);
      core.rd(mac_pkg::MAC_ADDR_RND_HI, rv);
      check("rnd_hi", rv, rnd[15:8]);
    end
    // A second reset in mid-run brings every register back to its reset value.
    #1 srst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 srst = 1'b0;
    {acc, rnd, sat, frac, monly, opa, opb} = '0;
    sta = mac_pkg::MAC_STA_RST;
    compare_all();
    core.rd(mac_pkg::MAC_ADDR_CONFIG, rv);
    check("config", rv, mac_pkg::MAC_CFG_RST);
    finish_test();
  end
endmodule
`default_nettype wire
